/* hdl/scan_tap_cfg.svh */
// constants of the boundary-scan test port
`ifndef SCAN_TAP_CFG_SVH
`define SCAN_TAP_CFG_SVH
`define IR_W 3
`define IR_CAPTURE_VAL 3'h1
`define ID_W 32
`define ID_REV_HI 31
`define ID_REV_LO 29
`define ID_PART_HI 28
`define ID_PART_LO 12
`define ID_MFR_HI 11
`define ID_MFR_LO 1
`define ID_PRESENT_BIT 0
`define BSR_LEN 109
`define BSR_PINS 108
`define BSR_CTRL_CELL 108
`define BSR_RESET_VAL {1'b1, 108'h0}
`endif

/* hdl/scan_tap_pkg.sv */
// types of the boundary-scan test port
package scan_tap_pkg;
    typedef enum logic [3:0] {
        TLR = 4'b1111, RTI = 4'b1100, SEL_DR = 4'b0111, CAP_DR = 4'b0110,
        SH_DR = 4'b0010, EX1_DR = 4'b0001, PA_DR = 4'b0011, EX2_DR = 4'b0000,
        UPD_DR = 4'b0101, SEL_IR = 4'b0100, CAP_IR = 4'b1110, SH_IR = 4'b1010,
        EX1_IR = 4'b1001, PA_IR = 4'b1011, EX2_IR = 4'b1000, UPD_IR = 4'b1101
    } tap_state_e;

    typedef enum logic [2:0] {
        I_EXTEST = 3'b000, I_IDCODE = 3'b001, I_SAMPLEZ = 3'b010, I_RSV3 = 3'b011,
        I_PRELOAD = 3'b100, I_RSV5 = 3'b101, I_RSV6 = 3'b110, I_BYPASS = 3'b111
    } instr_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_s;
endpackage : scan_tap_pkg

/* hdl/boundary_ring.sv */
// boundary-scan register: shift stage plus update latch
`include "scan_tap_cfg.svh"
module boundary_ring (
    input wire logic clock,
    input wire logic rstn,
    input wire logic preset,
    input wire logic capture_en,
    input wire logic shift_en,
    input wire logic update_en,
    input wire logic si,
    input wire logic [`BSR_PINS-1:0] pins,
    output logic so,
    output logic [`BSR_LEN-1:0] upd_q
);
    logic [`BSR_LEN-1:0] sh_q, sh_d, upd_d;

    always_comb begin
        sh_d = sh_q;
        upd_d = upd_q;
        if (capture_en) begin
            // internal cell samples its own latched value
            sh_d = {upd_q[`BSR_CTRL_CELL], pins};
        end else if (shift_en) begin
            sh_d = {si, sh_q[`BSR_LEN-1:1]};
        end
        if (preset) begin
            upd_d = `BSR_RESET_VAL;
        end else if (update_en) begin
            upd_d = sh_q;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            sh_q <= '0;
            upd_q <= `BSR_RESET_VAL;
        end else begin
            sh_q <= sh_d;
            upd_q <= upd_d;
        end
    end

    assign so = sh_q[0];
endmodule : boundary_ring

/* hdl/scan_tap.sv */
// boundary-scan test access port of a burst memory
// How it works
// - three-bit instruction; code 001 puts 32-bit id register in path
// - code 010 captures pins, selects boundary register, tri-states memory outputs
// - code 100 captures ring, selects boundary register, memory untouched
// - code 111 selects one-bit bypass register, memory untouched
// - id bits 31:29 revision, 28:12 part type, fixed per variant
// - id bits 11:1 hold fixed maker code
// - id bit 0 always one
// - boundary register 109 cells, cell 0 at output, last internal
// - external test drives preloaded values onto output pins
// - cell 108 enables output drivers under external test, presets high
`include "scan_tap_cfg.svh"
module scan_tap
    import scan_tap_pkg::*;
#(
    parameter logic [2:0] ID_REV = 3'h5, // arbitrary value
    parameter logic [16:0] ID_PART = 17'h0A5A5, // arbitrary value
    parameter logic [10:0] ID_MFR = 11'h155 // arbitrary value
) (
    input wire logic clock,
    input wire logic rstn,
    input wire tap_pins_s tap,
    input wire logic [`BSR_PINS-1:0] ring_in,
    output logic tdo_q,
    output logic tdo_oen_q,
    output logic extest_q,
    output logic qbus_oen_q,
    output logic [`BSR_LEN-1:0] ring_out
);
    localparam logic [`ID_W-1:0] ID_VAL = {ID_REV, ID_PART, ID_MFR, 1'b1};

    // two-stage sync; tck gets a third stage for edges, all in lockstep
    tap_pins_s s1_q, s2_q;
    logic tck3_q;
    logic [`BSR_PINS-1:0] ring_s1_q, ring_s2_q;
    logic rise, fall;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s1_q <= '0;
            s2_q <= '0;
            tck3_q <= 1'b0;
            ring_s1_q <= '0;
            ring_s2_q <= '0;
        end else begin
            s1_q <= tap;
            s2_q <= s1_q;
            tck3_q <= s2_q.tck;
            ring_s1_q <= ring_in;
            ring_s2_q <= ring_s1_q;
        end
    end

    assign rise = s2_q.tck & ~tck3_q;
    assign fall = ~s2_q.tck & tck3_q;

    // controller
    tap_state_e st_q, st_d;
    logic [`IR_W-1:0] ir_sh_q, ir_sh_d;
    instr_e ir_q, ir_d;
    logic [`ID_W-1:0] id_q, id_d;
    logic byp_q, byp_d;
    logic tdo_d, tdo_oen_d, extest_d, qbus_oen_d;
    logic bsr_sel, id_sel, bsr_so;

    assign id_sel = (ir_q == I_IDCODE);
    assign bsr_sel = (ir_q == I_EXTEST) || (ir_q == I_SAMPLEZ) || (ir_q == I_PRELOAD);

    always_comb begin
        st_d = st_q;
        if (rise) begin
            case (st_q)
                TLR: st_d = s2_q.tms ? TLR : RTI;
                RTI: st_d = s2_q.tms ? SEL_DR : RTI;
                SEL_DR: st_d = s2_q.tms ? SEL_IR : CAP_DR;
                CAP_DR: st_d = s2_q.tms ? EX1_DR : SH_DR;
                SH_DR: st_d = s2_q.tms ? EX1_DR : SH_DR;
                EX1_DR: st_d = s2_q.tms ? UPD_DR : PA_DR;
                PA_DR: st_d = s2_q.tms ? EX2_DR : PA_DR;
                EX2_DR: st_d = s2_q.tms ? UPD_DR : SH_DR;
                UPD_DR: st_d = s2_q.tms ? SEL_DR : RTI;
                SEL_IR: st_d = s2_q.tms ? TLR : CAP_IR;
                CAP_IR: st_d = s2_q.tms ? EX1_IR : SH_IR;
                SH_IR: st_d = s2_q.tms ? EX1_IR : SH_IR;
                EX1_IR: st_d = s2_q.tms ? UPD_IR : PA_IR;
                PA_IR: st_d = s2_q.tms ? EX2_IR : PA_IR;
                EX2_IR: st_d = s2_q.tms ? UPD_IR : SH_IR;
                UPD_IR: st_d = s2_q.tms ? SEL_DR : RTI;
                default: st_d = TLR;
            endcase
        end
    end

    always_comb begin
        ir_sh_d = ir_sh_q;
        ir_d = ir_q;
        id_d = id_q;
        byp_d = byp_q;
        if (st_q == TLR) begin
            ir_d = I_IDCODE;
        end else if (rise) begin
            case (st_q)
                CAP_IR: ir_sh_d = `IR_CAPTURE_VAL;
                SH_IR: ir_sh_d = {s2_q.tdi, ir_sh_q[`IR_W-1:1]};
                // reserved codes fall back to bypass behaviour
                UPD_IR: ir_d = instr_e'(ir_sh_q);
                CAP_DR: begin
                    id_d = ID_VAL;
                    byp_d = 1'b0;
                end
                SH_DR: begin
                    id_d = {s2_q.tdi, id_q[`ID_W-1:1]};
                    byp_d = s2_q.tdi;
                end
                default: begin
                end
            endcase
        end
    end

    // tdo changes only on falling tck so the tester samples a settled bit
    always_comb begin
        tdo_d = tdo_q;
        tdo_oen_d = tdo_oen_q;
        if (fall) begin
            tdo_oen_d = !((st_q == SH_DR) || (st_q == SH_IR));
            if (st_q == SH_IR) begin
                tdo_d = ir_sh_q[0];
            end else if (id_sel) begin
                tdo_d = id_q[0];
            end else if (bsr_sel) begin
                tdo_d = bsr_so;
            end else begin
                tdo_d = byp_q;
            end
        end
    end

    always_comb begin
        extest_d = (ir_q == I_EXTEST);
        qbus_oen_d = (ir_q == I_SAMPLEZ) || (extest_d && !ring_out[`BSR_CTRL_CELL]);
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_q <= TLR;
            ir_sh_q <= '0;
            ir_q <= I_IDCODE;
            id_q <= '0;
            byp_q <= 1'b0;
            tdo_q <= 1'b0;
            tdo_oen_q <= 1'b1;
            extest_q <= 1'b0;
            qbus_oen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ir_sh_q <= ir_sh_d;
            ir_q <= ir_d;
            id_q <= id_d;
            byp_q <= byp_d;
            tdo_q <= tdo_d;
            tdo_oen_q <= tdo_oen_d;
            extest_q <= extest_d;
            qbus_oen_q <= qbus_oen_d;
        end
    end

    boundary_ring boundary_ring_inst (
        .clock(clock),
        .rstn(rstn),
        .preset(st_q == TLR),
        .capture_en(rise && bsr_sel && (st_q == CAP_DR)),
        .shift_en(rise && bsr_sel && (st_q == SH_DR)),
        .update_en(rise && bsr_sel && (st_q == UPD_DR)),
        .si(s2_q.tdi),
        .pins(ring_s2_q),
        .so(bsr_so),
        .upd_q(ring_out)
    );

    // checks
    property p_id_capture;
        @(posedge clock) disable iff (!rstn)
        rise && st_q == CAP_DR |=> id_q == ID_VAL && id_q[`ID_PRESENT_BIT];
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("id capture wrong");
    property p_id_fields;
        @(posedge clock) disable iff (!rstn)
        rise && st_q == CAP_DR |=> id_q[`ID_REV_HI:`ID_REV_LO] == ID_REV && id_q[`ID_PART_HI:`ID_PART_LO] == ID_PART;
    endproperty
    a_id_fields: assert property (p_id_fields) else $error("id fields wrong");
    property p_id_mfr;
        @(posedge clock) disable iff (!rstn)
        rise && st_q == CAP_DR |=> id_q[`ID_MFR_HI:`ID_MFR_LO] == ID_MFR;
    endproperty
    a_id_mfr: assert property (p_id_mfr) else $error("maker code wrong");
    property p_samplez_hiz;
        @(posedge clock) disable iff (!rstn)
        ir_q == I_SAMPLEZ |=> qbus_oen_q;
    endproperty
    a_samplez_hiz: assert property (p_samplez_hiz) else $error("outputs not tri-stated");
    property p_preload_quiet;
        @(posedge clock) disable iff (!rstn)
        ir_q == I_PRELOAD || ir_q == I_BYPASS |=> !qbus_oen_q && !extest_q;
    endproperty
    a_preload_quiet: assert property (p_preload_quiet) else $error("memory disturbed");
    property p_bypass_cap;
        @(posedge clock) disable iff (!rstn)
        rise && st_q == CAP_DR |=> !byp_q;
    endproperty
    a_bypass_cap: assert property (p_bypass_cap) else $error("bypass not cleared");
    property p_extest_ctrl;
        @(posedge clock) disable iff (!rstn)
        ir_q == I_EXTEST && !ring_out[`BSR_CTRL_CELL] |=> extest_q && qbus_oen_q;
    endproperty
    a_extest_ctrl: assert property (p_extest_ctrl) else $error("control cell ignored");
    property p_tlr_preset;
        @(posedge clock) disable iff (!rstn)
        st_q == TLR |=> ring_out[`BSR_CTRL_CELL] && ir_q == I_IDCODE;
    endproperty
    a_tlr_preset: assert property (p_tlr_preset) else $error("reset preset missing");
    property p_tms_hold;
        @(posedge clock) disable iff (!rstn)
        rise && st_q == TLR && s2_q.tms |=> st_q == TLR;
    endproperty
    a_tms_hold: assert property (p_tms_hold) else $error("left reset state");
    property p_tdo_fall;
        @(posedge clock) disable iff (!rstn)
        fall && st_q == SH_DR |=> !tdo_oen_q;
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo not driven");
    c_idcode: cover property (@(posedge clock) rise && st_q == SH_DR && id_sel);
    c_extest: cover property (@(posedge clock) extest_q && !qbus_oen_q);
    c_samplez: cover property (@(posedge clock) ir_q == I_SAMPLEZ && qbus_oen_q);
endmodule : scan_tap

/* verif/tap_host.sv */
// behavioural test controller driving the scan port pins
module tap_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 100;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // tms/tdi change while tck low; tdo taken at end of high phase, long after the device's late update
    task step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #(HALF) tck = 1'b1;
        #(HALF) o = tdo;
        tck = 1'b0;
    endtask : step

    task go_idle;
        logic o;
        step(1'b0, 1'b0, o);
    endtask : go_idle

    // from run-test/idle through capture, shift and update, back to idle; lsb first
    task shift(input logic ir, input int n, input logic [108:0] din, output logic [108:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b0, o);
        if (ir) begin
            step(1'b1, 1'b0, o);
        end
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        // tck edges reach the port several system clocks late
        #(2 * HALF);
    endtask : shift

    task reset_seq;
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
        step(1'b0, 1'b0, o);
        #(2 * HALF);
    endtask : reset_seq
endmodule : tap_host

/* verif/tb_scan_tap.sv */
// self-checking bench of the boundary-scan test port
module tb_scan_tap
    import scan_tap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [2:0] REV = 3'h2; // arbitrary value
    localparam logic [16:0] PART = 17'h1234B; // arbitrary value
    localparam logic [10:0] MFR = 11'h2C3; // arbitrary value
    localparam logic [31:0] ID = {REV, PART, MFR, 1'b1};
    localparam logic [108:0] P1 = {1'b1, {27{4'h5}}};
    localparam logic [108:0] P2 = {1'b0, {27{4'hC}}};
    // control cell low, so the later external test starts with the bus released
    localparam logic [108:0] P3 = {1'b0, {27{4'h3}}};
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [107:0] ring_in = {27{4'hA}};
    logic tck, tms, tdi;
    tap_pins_s pins;
    logic tdo_q, tdo_oen_q, extest_q, qbus_oen_q;
    logic [108:0] ring_out, got;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // released data-out idles high through its pull-up
    wire tdo_line = tdo_oen_q ? 1'b1 : tdo_q;
    assign pins = {tck, tms, tdi};

    always #12.5 clock = ~clock;

    scan_tap #(.ID_REV(REV), .ID_PART(PART), .ID_MFR(MFR)) scan_tap_inst (
        .clock(clock), .rstn(rstn), .tap(pins), .ring_in(ring_in), .tdo_q(tdo_q),
        .tdo_oen_q(tdo_oen_q), .extest_q(extest_q), .qbus_oen_q(qbus_oen_q), .ring_out(ring_out));
    tap_host tap_host_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

    task give_verdict;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task check(input logic [108:0] seen, input logic [108:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // order: external test, bus high-z, data-out released
    task flags(input logic [2:0] exp);
        check({106'h0, extest_q, qbus_oen_q, tdo_oen_q}, {106'h0, exp});
    endtask : flags

    // only documented codes are ever loaded; capture pattern is 001
    task load_ir(input logic [2:0] code);
        tap_host_inst.shift(1'b1, 3, {106'h0, code}, got);
        check({106'h0, got[2:0]}, {106'h0, 3'h1});
    endtask : load_ir

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clock);
        #2;
        flags(3'b001);
        check(ring_out, {1'b1, 108'h0});
        rstn = 1'b1;
        tap_host_inst.go_idle();
        tap_host_inst.shift(1'b0, 32, 109'h0, got);
        check({77'h0, got[31:0]}, {77'h0, ID});
        load_ir(3'h4);
        tap_host_inst.shift(1'b0, 109, P1, got);
        check(got, {1'b1, ring_in});
        check(ring_out, P1);
        flags(3'b001);
        load_ir(3'h0);
        flags(3'b101);
        tap_host_inst.shift(1'b0, 109, P2, got);
        check(got, {1'b1, ring_in});
        check(ring_out, P2);
        flags(3'b111);
        load_ir(3'h2);
        flags(3'b011);
        tap_host_inst.shift(1'b0, 109, P3, got);
        check(got, {1'b0, ring_in});
        check(ring_out, P3);
        load_ir(3'h7);
        flags(3'b001);
        tap_host_inst.shift(1'b0, 8, {101'h0, 8'hB5}, got);
        check({101'h0, got[7:0]}, {101'h0, 8'h6A});
        load_ir(3'h0);
        flags(3'b111);
        tap_host_inst.reset_seq();
        // leaving external test via reset must re-enable the bus control cell
        check({108'h0, ring_out[108]}, {108'h0, 1'b1});
        flags(3'b001);
        tap_host_inst.shift(1'b0, 32, 109'h0, got);
        check({77'h0, got[31:0]}, {77'h0, ID});
        give_verdict();
    end
endmodule : tb_scan_tap
